// *** core/ccx_exec.sv ***
// Execution unit for subroutine jump, clear, watchdog clear and invert operations.
`timescale 1ns/10ps
`default_nettype none
`include "ccx_defs.svh"

// Behaviour
// - A subroutine jump pushes the program counter plus 1 onto the stack, then loads the target, with no flag change.
// - A subroutine jump takes two cycles, the push in the first and the program counter load in the second.
// - Clearing a byte writes all zeros to the addressed memory byte and touches no status flag.
// - Clearing a bit forces only the selected bit of the addressed byte to 0 and touches no status flag.
// - The watchdog clear resets the watchdog counter and drives the expiry and power-down flags to 0, except a flag whose set event arrives in the same cycle.
// - Inverting memory writes the one's complement of the byte back to it and updates the zero flag.
// - Inverting to working writes the complement into the working register, leaves memory alone, updates zero.
module ccx_exec
  import ccx_pkg::*;
(
  input  wire logic                      clk_sys_i,           // System clock, 100 MHz.
  input  wire logic                      rst_b_i,             // Asynchronous reset, active low.
  input  wire logic                      op_valid_i,          // Request strobe, one cycle.
  input  wire logic [`CCX_OP_W-1:0]      op_i,                // Operation code.
  input  wire logic [`CCX_PC_W-1:0]      pc_i,                // Address of the current instruction.
  input  wire logic [`CCX_PC_W-1:0]      target_i,            // Encoded jump target.
  input  wire logic [`CCX_MADDR_W-1:0]   mem_addr_i,          // Addressed data-memory location.
  input  wire logic [`CCX_BIT_IDX_W-1:0] bit_idx_i,           // Selected bit for a bit clear.
  input  wire logic [`CCX_DATA_W-1:0]    mem_rdata_i,         // Current content of the addressed byte.
  input  wire logic                      expiry_set_i,        // Watchdog time-out event.
  input  wire logic                      power_down_set_i,    // Power-down entry event.
  output logic                           busy_o,              // Jump in progress, requests ignored.
  output logic                           done_o,              // Operation finished, one cycle.
  output logic                           mem_we_o,            // Data-memory write strobe.
  output logic [`CCX_MADDR_W-1:0]        mem_waddr_o,         // Data-memory write address.
  output logic [`CCX_DATA_W-1:0]         mem_wdata_o,         // Data-memory write data.
  output logic                           stack_push_o,        // Stack push strobe.
  output logic [`CCX_PC_W-1:0]           stack_data_o,        // Return address pushed.
  output logic                           pc_load_o,           // Program counter load strobe.
  output logic [`CCX_PC_W-1:0]           pc_data_o,           // New program counter value.
  output logic                           working_we_o,        // Working register write strobe.
  output logic [`CCX_DATA_W-1:0]         working_data_o,      // Working register write data.
  output logic                           zero_we_o,           // Zero flag update strobe.
  output logic                           zero_o,              // New zero flag value.
  output logic                           watchdog_counter_clear_o, // Watchdog counter reset strobe.
  output logic                           watchdog_expiry_flag_o,   // Watchdog expiry flag.
  output logic                           power_down_flag_o         // Power-down flag.
);

  ccx_state_t state_q;
  ccx_state_t state_d;

  // Requests are only taken while idle; a jump holds the unit for its second cycle.
  wire logic take_w = op_valid_i && (state_q == CCX_ST_IDLE);
  wire logic is_jump_w     = take_w && (op_i == CCX_OP_SUB_JUMP);
  wire logic is_clr_byte_w = take_w && (op_i == CCX_OP_CLEAR_BYTE);
  wire logic is_clr_bit_w  = take_w && (op_i == CCX_OP_CLEAR_BIT);
  wire logic is_wd_clear_w = take_w && (op_i == CCX_OP_CLEAR_WATCHDOG);
  wire logic is_inv_mem_w  = take_w && (op_i == CCX_OP_INVERT_MEMORY);
  wire logic is_inv_wrk_w  = take_w && (op_i == CCX_OP_INVERT_WORKING);
  wire logic known_op_w    = is_jump_w || is_clr_byte_w || is_clr_bit_w || is_wd_clear_w
                             || is_inv_mem_w || is_inv_wrk_w;

  wire logic [`CCX_DATA_W-1:0] inverted_w  = ~mem_rdata_i;
  wire logic                   inv_zero_w  = (inverted_w == `CCX_ZERO_BYTE);
  wire logic [`CCX_PC_W-1:0]   ret_addr_w  = pc_i + `CCX_RET_OFFSET;

  // Bit clear mask built per bit; only the selected position is forced low.
  wire logic [`CCX_DATA_W-1:0] bit_cleared_w;
  genvar gi;
  generate
    for (gi = 0; gi < `CCX_DATA_W; gi = gi + 1) begin : g_bit
      assign bit_cleared_w[gi] = (bit_idx_i == `CCX_BIT_IDX_W'(gi)) ? 1'b0 : mem_rdata_i[gi];
    end
  endgenerate

  wire logic [`CCX_DATA_W-1:0] mem_wdata_w = is_clr_byte_w ? `CCX_ZERO_BYTE :
                                             is_clr_bit_w  ? bit_cleared_w  :
                                             inverted_w;
  wire logic mem_we_w = is_clr_byte_w || is_clr_bit_w || is_inv_mem_w;

  // Events win over a watchdog clear in the same cycle so that a time-out is never lost.
  wire logic expiry_d_w = expiry_set_i     ? 1'b1 : (is_wd_clear_w ? 1'b0 : watchdog_expiry_flag_o);
  wire logic pdown_d_w  = power_down_set_i ? 1'b1 : (is_wd_clear_w ? 1'b0 : power_down_flag_o);

  always_comb begin
    case (state_q)
      CCX_ST_IDLE:   state_d = is_jump_w ? CCX_ST_JUMP_2 : CCX_ST_IDLE;
      CCX_ST_JUMP_2: state_d = CCX_ST_IDLE;
      default:       state_d = CCX_ST_IDLE;
    endcase
  end

  logic [`CCX_PC_W-1:0] target_q;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q                  <= CCX_ST_IDLE;
      target_q                 <= '0;
      busy_o                   <= 1'b0;
      done_o                   <= 1'b0;
      stack_push_o             <= 1'b0;
      stack_data_o             <= '0;
      pc_load_o                <= 1'b0;
      pc_data_o                <= '0;
    end else begin
      state_q      <= state_d;
      busy_o       <= (state_d == CCX_ST_JUMP_2);
      done_o       <= (known_op_w && !is_jump_w) || (state_q == CCX_ST_JUMP_2);
      stack_push_o <= is_jump_w;
      if (is_jump_w) begin
        stack_data_o <= ret_addr_w;
        target_q     <= target_i;
      end
      pc_load_o <= (state_q == CCX_ST_JUMP_2);
      if (state_q == CCX_ST_JUMP_2) begin
        pc_data_o <= target_q;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_we_o                 <= 1'b0;
      mem_waddr_o              <= '0;
      mem_wdata_o              <= '0;
      working_we_o             <= 1'b0;
      working_data_o           <= '0;
      zero_we_o                <= 1'b0;
      zero_o                   <= 1'b0;
      watchdog_counter_clear_o <= 1'b0;
      watchdog_expiry_flag_o   <= 1'b0;
      power_down_flag_o        <= 1'b0;
    end else begin
      mem_we_o     <= mem_we_w;
      working_we_o <= is_inv_wrk_w;
      zero_we_o    <= is_inv_mem_w || is_inv_wrk_w;
      if (mem_we_w) begin
        mem_waddr_o <= mem_addr_i;
        mem_wdata_o <= mem_wdata_w;
      end
      if (is_inv_wrk_w) begin
        working_data_o <= inverted_w;
      end
      if (is_inv_mem_w || is_inv_wrk_w) begin
        zero_o <= inv_zero_w;
      end
      watchdog_counter_clear_o <= is_wd_clear_w;
      watchdog_expiry_flag_o   <= expiry_d_w;
      power_down_flag_o        <= pdown_d_w;
    end
  end

  // Checks kept beside the logic they guard.
  chk_jump_push_then_load: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    stack_push_o |=> pc_load_o && !stack_push_o)
    else $error("jump load did not follow the push by one cycle");

  chk_jump_return_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (op_valid_i && !busy_o && op_i == CCX_OP_SUB_JUMP)
      |=> stack_push_o && stack_data_o == $past(pc_i) + `CCX_RET_OFFSET ##1 pc_data_o == $past(target_i, 2))
    else $error("jump pushed a wrong return address or loaded a wrong target");

  chk_jump_no_flags: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (stack_push_o || pc_load_o) |-> !zero_we_o && !mem_we_o && !working_we_o)
    else $error("jump disturbed flags or memory");

  chk_clear_byte_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take_w && op_i == CCX_OP_CLEAR_BYTE)
      |=> mem_we_o && mem_wdata_o == `CCX_ZERO_BYTE && !zero_we_o && mem_waddr_o == $past(mem_addr_i))
    else $error("byte clear wrote a nonzero value or touched a flag");

  chk_clear_bit_only: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take_w && op_i == CCX_OP_CLEAR_BIT)
      |=> mem_we_o && !zero_we_o
          && mem_wdata_o == ($past(mem_rdata_i) & ~(8'h01 << $past(bit_idx_i))))
    else $error("bit clear changed more than the selected bit");

  chk_watchdog_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take_w && op_i == CCX_OP_CLEAR_WATCHDOG && !expiry_set_i && !power_down_set_i)
      |=> watchdog_counter_clear_o && !watchdog_expiry_flag_o && !power_down_flag_o)
    else $error("watchdog clear left a flag set or did not reset the counter");

  chk_invert_memory: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take_w && op_i == CCX_OP_INVERT_MEMORY)
      |=> mem_we_o && mem_wdata_o == ~$past(mem_rdata_i) && zero_we_o && !working_we_o)
    else $error("memory inversion wrote a wrong byte");

  chk_invert_working: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take_w && op_i == CCX_OP_INVERT_WORKING)
      |=> working_we_o && working_data_o == ~$past(mem_rdata_i) && !mem_we_o && zero_we_o)
    else $error("working inversion wrote memory or a wrong value");

  chk_zero_value: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take_w && (op_i == CCX_OP_INVERT_MEMORY || op_i == CCX_OP_INVERT_WORKING))
      |=> zero_o == ($past(mem_rdata_i) == 8'hff))
    else $error("zero flag does not match the result");

  chk_busy_refuses_req: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    busy_o |=> !mem_we_o && !working_we_o && !zero_we_o && !watchdog_counter_clear_o && !stack_push_o)
    else $error("a request was taken during the second jump cycle");

  chk_jump_done_late: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    stack_push_o |-> !done_o ##1 (done_o && pc_load_o))
    else $error("jump finished in the wrong cycle");

  chk_expiry_set_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    expiry_set_i |=> watchdog_expiry_flag_o)
    else $error("expiry event was lost");

  chk_pdown_set_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    power_down_set_i |=> power_down_flag_o)
    else $error("power-down event was lost");

  chk_zero_not_on_jump: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    zero_we_o |-> !stack_push_o && !pc_load_o && !mem_we_o || !stack_push_o && !pc_load_o)
    else $error("zero flag written during a jump");

endmodule
`default_nettype wire

// *** core/ccx_defs.svh ***
// Widths and fixed values for the call, clear and invert execution block.
`ifndef CCX_DEFS_SVH
`define CCX_DEFS_SVH
`define CCX_DATA_W      8
`define CCX_MADDR_W     8
`define CCX_PC_W        13
`define CCX_BIT_IDX_W   3
`define CCX_OP_W        3
`define CCX_RET_OFFSET  13'h0001
`define CCX_ZERO_BYTE   8'h00
`define CCX_CALL_CYCLES 2
`endif

// *** core/ccx_pkg.sv ***
// Operation and state types for the call, clear and invert execution block.
`include "ccx_defs.svh"
package ccx_pkg;
  typedef enum logic [`CCX_OP_W-1:0] {
    CCX_OP_SUB_JUMP       = 3'b000,
    CCX_OP_CLEAR_BYTE     = 3'b001,
    CCX_OP_CLEAR_BIT      = 3'b010,
    CCX_OP_CLEAR_WATCHDOG = 3'b011,
    CCX_OP_INVERT_MEMORY  = 3'b100,
    CCX_OP_INVERT_WORKING = 3'b101
  } ccx_op_t;

  typedef enum logic [0:0] {
    CCX_ST_IDLE   = 1'b0,
    CCX_ST_JUMP_2 = 1'b1
  } ccx_state_t;
endpackage

// *** testbench/ccx_cpu_model.sv ***
// Behavioural model of the data memory, stack and program counter around the execution block.
`timescale 1ns/10ps
`default_nettype none
`include "ccx_defs.svh"
module ccx_cpu_model (
  input  wire logic                    clk_sys_i,    // System clock.
  input  wire logic [`CCX_MADDR_W-1:0] mem_addr_i,   // Read address.
  input  wire logic                    mem_we_i,     // Write strobe.
  input  wire logic [`CCX_MADDR_W-1:0] mem_waddr_i,  // Write address.
  input  wire logic [`CCX_DATA_W-1:0]  mem_wdata_i,  // Write data.
  input  wire logic                    stack_push_i, // Push strobe.
  input  wire logic [`CCX_PC_W-1:0]    stack_data_i, // Pushed value.
  input  wire logic                    pc_load_i,    // Load strobe.
  input  wire logic [`CCX_PC_W-1:0]    pc_data_i,    // Loaded value.
  output logic      [`CCX_DATA_W-1:0]  mem_rdata_o,  // Byte at the read address.
  output logic      [`CCX_PC_W-1:0]    stack_top_o,  // Last pushed address.
  output logic      [`CCX_PC_W-1:0]    pc_o          // Program counter.
);
  logic [`CCX_DATA_W-1:0] mem [256];

  // The byte is read without delay, as the block expects it with the request.
  assign mem_rdata_o = mem[mem_addr_i];

  always @(posedge clk_sys_i) begin
    if (mem_we_i) mem[mem_waddr_i] <= mem_wdata_i;
    if (stack_push_i) stack_top_o <= stack_data_i;
    if (pc_load_i) pc_o <= pc_data_i;
  end
endmodule
`default_nettype wire

// *** testbench/tb_mcu_call_clear_complement_exec.sv ***
// Self-checking bench for the call, clear and invert execution block.
`timescale 1ns/10ps
`default_nettype none
`include "ccx_defs.svh"
module tb_mcu_call_clear_complement_exec import ccx_pkg::*;;
  logic        clk = 1'b0, rst_b = 1'b0, op_valid = 1'b0, exp_set = 1'b0, pd_set = 1'b0;
  logic [2:0]  op = 3'h0, bidx = 3'h0;
  logic [7:0]  addr = 8'h00, rdata, wdata, waddr, wk_data;
  logic [12:0] pc = 13'h0000, tgt = 13'h0000, stk_data, pc_data, stk_top, pc_now;
  logic        busy, done, mem_we, stk_push, pc_load, wk_we, z_we, z, wdc, exp_f, pd_f;
  int          errors = 0, check_count = 0, cycles = 0;

  always #5 clk = ~clk;

  ccx_exec u_dut (.clk_sys_i(clk), .rst_b_i(rst_b), .op_valid_i(op_valid), .op_i(op), .pc_i(pc),
    .target_i(tgt), .mem_addr_i(addr), .bit_idx_i(bidx), .mem_rdata_i(rdata), .expiry_set_i(exp_set),
    .power_down_set_i(pd_set), .busy_o(busy), .done_o(done), .mem_we_o(mem_we), .mem_waddr_o(waddr),
    .mem_wdata_o(wdata), .stack_push_o(stk_push), .stack_data_o(stk_data), .pc_load_o(pc_load),
    .pc_data_o(pc_data), .working_we_o(wk_we), .working_data_o(wk_data), .zero_we_o(z_we), .zero_o(z),
    .watchdog_counter_clear_o(wdc), .watchdog_expiry_flag_o(exp_f), .power_down_flag_o(pd_f));
  ccx_cpu_model u_mdl (.clk_sys_i(clk), .mem_addr_i(addr), .mem_we_i(mem_we), .mem_waddr_i(waddr),
    .mem_wdata_i(wdata), .stack_push_i(stk_push), .stack_data_i(stk_data), .pc_load_i(pc_load),
    .pc_data_i(pc_data), .mem_rdata_o(rdata), .stack_top_o(stk_top), .pc_o(pc_now));

  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  // Raises a request and returns just after the edge; the strobe stays up so back-to-back calls never toggle it.
  task automatic req(input logic [2:0] code, input logic [7:0] a, input logic [2:0] b);
    op_valid = 1'b1;
    op = code;
    addr = a;
    bidx = b;
    @(posedge clk);
    #1;
  endtask

  task automatic rel;
    op_valid = 1'b0;
  endtask

  task automatic t_jump;
    pc = 13'h1fff;
    tgt = 13'h0abc;
    u_mdl.mem[8'h20] = 8'h77;
    req(CCX_OP_SUB_JUMP, 8'h20, 3'h0);
    chk(stk_push === 1'b1 && stk_data === 13'h0000 && busy === 1'b1, "push");
    chk(pc_load === 1'b0 && done === 1'b0 && z_we === 1'b0, "early load");
    req(CCX_OP_CLEAR_BYTE, 8'h20, 3'h0);
    chk(pc_load === 1'b1 && pc_data === 13'h0abc && done === 1'b1 && busy === 1'b0, "load");
    chk(mem_we === 1'b0 && z_we === 1'b0 && stk_top === 13'h0000, "busy request");
    rel();
    @(posedge clk);
    #1;
    chk(pc_now === 13'h0abc && u_mdl.mem[8'h20] === 8'h77, "pc loaded, refused clear");
    $display("test jump done");
  endtask

  task automatic t_clear;
    u_mdl.mem[8'h40] = 8'ha5;
    req(CCX_OP_CLEAR_BYTE, 8'h40, 3'h0);
    chk(mem_we === 1'b1 && waddr === 8'h40 && wdata === 8'h00 && done === 1'b1 && z_we === 1'b0, "clr");
    for (int i = 0; i < 8; i++) begin
      u_mdl.mem[8'h50 + i[7:0]] = 8'h3c;
      req(CCX_OP_CLEAR_BIT, 8'h50 + i[7:0], i[2:0]);
      chk(mem_we === 1'b1 && wdata === (8'h3c & ~(8'h01 << i)) && z_we === 1'b0, "clear bit");
    end
    rel();
    $display("test clear done");
  endtask

  task automatic t_watchdog;
    exp_set = 1'b1;
    pd_set = 1'b1;
    @(posedge clk);
    #1 exp_set = 1'b0;
    pd_set = 1'b0;
    chk(exp_f === 1'b1 && pd_f === 1'b1, "flags set");
    req(CCX_OP_CLEAR_WATCHDOG, 8'h00, 3'h0);
    chk(wdc === 1'b1 && exp_f === 1'b0 && pd_f === 1'b0 && done === 1'b1, "watchdog clear");
    exp_set = 1'b1;
    req(CCX_OP_CLEAR_WATCHDOG, 8'h00, 3'h0);
    exp_set = 1'b0;
    rel();
    chk(wdc === 1'b1 && exp_f === 1'b1 && pd_f === 1'b0, "event wins over clear");
    $display("test watchdog done");
  endtask

  task automatic t_invert;
    logic [7:0] v [3] = '{8'hff, 8'h5a, 8'h00};
    for (int i = 0; i < 3; i++) begin
      u_mdl.mem[8'h60] = v[i];
      u_mdl.mem[8'h61] = v[i];
      req(CCX_OP_INVERT_MEMORY, 8'h60, 3'h0);
      chk(mem_we === 1'b1 && waddr === 8'h60 && wdata === ~v[i] && done === 1'b1, "inv mem");
      chk(z_we === 1'b1 && z === ((~v[i]) == 8'h00), "inv mem zero");
      req(CCX_OP_INVERT_WORKING, 8'h61, 3'h0);
      chk(wk_we === 1'b1 && wk_data === ~v[i] && mem_we === 1'b0 && done === 1'b1, "inv wk");
      chk(z_we === 1'b1 && z === ((~v[i]) == 8'h00) && u_mdl.mem[8'h60] === ~v[i], "inv wk zero");
    end
    rel();
    $display("test invert done");
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // The tests need well under 200 cycles; the ceiling leaves a wide margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    t_jump();
    t_clear();
    t_watchdog();
    t_invert();
    finish_test();
  end
endmodule
`default_nettype wire
